// >>> dew_pkg.sv
// Package: constants and carrier types for the data EEPROM write controller
package dew_pkg;
  // ==================================================
  // Address split
  localparam int DEW_PAGE_W = 5;
  localparam int DEW_BYTE_W = 4;
  localparam int DEW_ADDR_W = DEW_PAGE_W + DEW_BYTE_W;
  localparam int DEW_DATA_W = 8;
  localparam int DEW_PAGE_BYTES = 16;
  localparam logic [DEW_BYTE_W-1:0] DEW_BYTE_LAST = 4'hF;
  // ==================================================
  // Control register fields
  localparam int DEW_BIT_MODE = 4;
  localparam int DEW_BIT_WEN  = 3;
  localparam int DEW_BIT_WST  = 2;
  localparam logic [7:0] DEW_CTRL_RST = 8'h00;
  localparam logic [7:0] DEW_PTR_RST  = 8'h00;
  localparam logic [7:0] DEW_CTRL_SECTOR = 8'h01;
  // ==================================================
  // Timing
  localparam int DEW_CLK_MHZ   = 40;
  localparam int DEW_ERASE_US  = 2;
  localparam int DEW_ERASE_CYC = DEW_ERASE_US * DEW_CLK_MHZ;

  typedef enum logic [1:0] {
    DEW_IDLE  = 2'b00,
    DEW_ERASE = 2'b01,
    DEW_PROG  = 2'b11
  } dew_state_t;

  // CPU write strobes into the register slots
  typedef struct packed {
    logic                  ctrl_we;
    logic [7:0]            ctrl_wdata;
    logic                  data_we;
    logic [DEW_DATA_W-1:0] data_wdata;
    logic                  addr_we;
    logic [DEW_ADDR_W-1:0] addr_wdata;
  } dew_cpu_wr_t;

  // Request to the array
  typedef struct packed {
    logic                  erase;
    logic                  prog;
    logic                  page;
    logic [DEW_ADDR_W-1:0] addr;
  } dew_nvm_req_t;
endpackage

// >>> dew_sync.sv
// Two-stage synchroniser with edge pulse for the timer domain done level
`timescale 1ns/10ps
module dew_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Async level and its synced rising edge
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_pulse = sync_reg & ~last_reg;
endmodule

// >>> dew_ctrl.sv
// Data EEPROM write controller: activation, page buffer, cycle handshake, flags
// Function
// - Mode zero writes the data byte to the high/low address.
// - Start must follow enable in the very next cycle.
// - Start while enable is low is ignored; no cycle begins.
// - Program phase length comes from an asynchronous timer; byte-mode erase counts clock cycles.
// - Hardware clears write_start when the cycle completes.
// - Hardware clears write_enable after the write completes.
// - Byte mode erases the addressed byte before programming it.
// - Mode one writes pages of up to sixteen bytes, same activation.
// - Page buffer cleared at power-on reset.
// - Buffer cleared when write_enable falls, kept when it rises.
// - Upper five address bits pick page, lower four pick byte.
// - In page mode each data write loads buffer and bumps offset.
// - Auto-increment never touches the page-select bits.
// - Offset saturates at 0FH; later data writes are ignored.
// - Power-on clears write_enable.
// - Pointer high bytes reset to zero; control needs sector one.
// - Cycle end sets EEPROM flag and multi-function flag.
// - Vector only when all enables set and stack not full.
// - Servicing clears only multi-function flag; software clears EEPROM flag.
// - Control bits: mode 4, write_enable 3, write_start 2.
`timescale 1ns/10ps
module dew_ctrl
  import dew_pkg::*;
#(
  parameter int PAGE_BYTES = DEW_PAGE_BYTES
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  // CPU register writes and pointer
  input  wire dew_pkg::dew_cpu_wr_t          cpu_wr,
  input  wire logic                          ptr_we,
  input  wire logic [7:0]                    ptr_wdata,
  // Interrupt controller side
  input  wire logic                          global_int_enable,
  input  wire logic                          eeprom_int_enable,
  input  wire logic                          mf_int_enable,
  input  wire logic                          stack_full,
  input  wire logic                          int_ack,
  input  wire logic                          eeprom_flag_clr,
  // Asynchronous timer done level
  input  wire logic                          timer_done,
  // Status and control views
  output logic [7:0]                         eeprom_ctrl_reg,
  output logic [7:0]                         mem_ptr1_high,
  output logic [dew_pkg::DEW_ADDR_W-1:0]     eeprom_addr_reg,
  output logic [dew_pkg::DEW_DATA_W-1:0]     eeprom_data_reg,
  output logic                               eeprom_int_flag,
  output logic                               mf_int_flag,
  output logic                               int_vector_req,
  // Array request
  output dew_pkg::dew_nvm_req_t              nvm_req,
  output logic [dew_pkg::DEW_DATA_W-1:0]     nvm_wdata,
  output logic [PAGE_BYTES*dew_pkg::DEW_DATA_W-1:0] page_buf_out,
  output logic [PAGE_BYTES-1:0]              page_tag_out
);
  import dew_pkg::*;

  logic [DEW_DATA_W-1:0] buf_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] tag_reg;
  logic                  mode_reg;
  logic                  wen_reg;
  logic                  wst_reg;
  logic                  wen_prev_reg;
  logic                  done_pulse;
  logic                  arm_reg;
  logic                  sel_ok;
  logic                  set_wen;
  logic                  set_wst;
  logic                  activate;
  logic [7:0]            erase_cnt_reg;
  dew_state_t            state_reg;

  // ==================================================
  // Timer completion crossing
  dew_sync u_sync (
    .clock      (clock),
    .reset_n    (reset_n),
    .async_in   (timer_done),
    .rise_pulse (done_pulse)
  );

  // ==================================================
  // Sector pointer
  always_ff @(posedge clock) begin
    if (!reset_n) mem_ptr1_high <= DEW_PTR_RST;
    else if (ptr_we) mem_ptr1_high <= ptr_wdata;
  end

  assign sel_ok  = (mem_ptr1_high == DEW_CTRL_SECTOR);
  assign set_wen = sel_ok & cpu_wr.ctrl_we & cpu_wr.ctrl_wdata[DEW_BIT_WEN];
  assign set_wst = sel_ok & cpu_wr.ctrl_we & cpu_wr.ctrl_wdata[DEW_BIT_WST];
  assign activate = set_wst & arm_reg & wen_reg & ~wst_reg;

  // ==================================================
  // Activation window
  always_ff @(posedge clock) begin
    if (!reset_n) arm_reg <= 1'b0;
    else arm_reg <= set_wen & ~cpu_wr.ctrl_wdata[DEW_BIT_WST];
  end

  // ==================================================
  // Control bits
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_reg <= DEW_CTRL_RST[DEW_BIT_MODE];
      wen_reg  <= DEW_CTRL_RST[DEW_BIT_WEN];
      wst_reg  <= DEW_CTRL_RST[DEW_BIT_WST];
    end else if (wst_reg) begin
      if (done_pulse) begin
        wst_reg <= 1'b0;
        wen_reg <= 1'b0;
      end
    end else if (sel_ok && cpu_wr.ctrl_we) begin
      mode_reg <= cpu_wr.ctrl_wdata[DEW_BIT_MODE];
      wen_reg  <= cpu_wr.ctrl_wdata[DEW_BIT_WEN];
      if (activate) wst_reg <= 1'b1;
      else if (arm_reg) wen_reg <= 1'b0;
    end else if (arm_reg) begin
      wen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) wen_prev_reg <= 1'b0;
    else wen_prev_reg <= wen_reg;
  end

  // ==================================================
  // Address and data registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      eeprom_addr_reg <= '0;
      eeprom_data_reg <= '0;
    end else if (!wst_reg) begin
      if (cpu_wr.addr_we) eeprom_addr_reg <= cpu_wr.addr_wdata;
      if (cpu_wr.data_we) begin
        eeprom_data_reg <= cpu_wr.data_wdata;
        if (mode_reg && !tag_reg[DEW_BYTE_LAST]
            && eeprom_addr_reg[DEW_BYTE_W-1:0] != DEW_BYTE_LAST)
          eeprom_addr_reg[DEW_BYTE_W-1:0] <=
            eeprom_addr_reg[DEW_BYTE_W-1:0] + 4'h1;
      end
    end
  end

  // ==================================================
  // Page buffer
  always_ff @(posedge clock) begin
    if (!reset_n || (wen_prev_reg && !wen_reg)) begin
      tag_reg <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) buf_mem[i] <= '0;
    end else if (!wst_reg && cpu_wr.data_we && mode_reg
                 && !tag_reg[DEW_BYTE_LAST]) begin
      buf_mem[eeprom_addr_reg[DEW_BYTE_W-1:0]] <= cpu_wr.data_wdata;
      tag_reg[eeprom_addr_reg[DEW_BYTE_W-1:0]] <= 1'b1;
    end
  end

  // ==================================================
  // Cycle sequencer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg     <= DEW_IDLE;
      erase_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        DEW_IDLE: begin
          if (activate) begin
            state_reg     <= mode_reg ? DEW_PROG : DEW_ERASE;
            erase_cnt_reg <= 8'(DEW_ERASE_CYC);
          end
        end
        DEW_ERASE: begin
          if (erase_cnt_reg == 8'h01) state_reg <= DEW_PROG;
          erase_cnt_reg <= erase_cnt_reg - 8'h01;
        end
        DEW_PROG: begin
          if (done_pulse) state_reg <= DEW_IDLE;
        end
        default: state_reg <= DEW_IDLE;
      endcase
    end
  end

  // ==================================================
  // Array request outputs
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nvm_req      <= '0;
      nvm_wdata    <= '0;
      page_tag_out <= '0;
      page_buf_out <= '0;
    end else begin
      nvm_req.erase <= (state_reg == DEW_ERASE);
      nvm_req.prog  <= (state_reg == DEW_PROG);
      nvm_req.page  <= mode_reg;
      nvm_req.addr  <= eeprom_addr_reg;
      nvm_wdata     <= eeprom_data_reg;
      page_tag_out  <= tag_reg;
      for (int i = 0; i < PAGE_BYTES; i++)
        page_buf_out[i*DEW_DATA_W +: DEW_DATA_W] <= buf_mem[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) eeprom_ctrl_reg <= DEW_CTRL_RST;
    else eeprom_ctrl_reg <= {3'h0, mode_reg, wen_reg, wst_reg, 2'h0};
  end

  // ==================================================
  // Interrupt flags
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      eeprom_int_flag <= 1'b0;
      mf_int_flag     <= 1'b0;
      int_vector_req  <= 1'b0;
    end else begin
      if (done_pulse && wst_reg) begin
        eeprom_int_flag <= 1'b1;
        mf_int_flag     <= 1'b1;
      end else begin
        if (eeprom_flag_clr) eeprom_int_flag <= 1'b0;
        if (int_ack) mf_int_flag <= 1'b0;
      end
      int_vector_req <= global_int_enable & eeprom_int_enable & mf_int_enable
                        & ~stack_full & mf_int_flag & ~int_ack;
    end
  end

  // ==================================================
  // Checks
  property p_ignore_start;
    @(posedge clock) disable iff (!reset_n)
      (set_wst && !arm_reg && !wst_reg) |=> !wst_reg;
  endproperty
  a_ignore_start: assert property (p_ignore_start) else $error("start taken without enable");

  property p_done_clears;
    @(posedge clock) disable iff (!reset_n)
      (done_pulse && wst_reg) |=> (!wst_reg && !wen_reg);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("done left bits set");

  property p_flags_set;
    @(posedge clock) disable iff (!reset_n)
      (done_pulse && wst_reg) |=> (eeprom_int_flag && mf_int_flag);
  endproperty
  a_flags_set: assert property (p_flags_set) else $error("flags not set on done");

  property p_wen_fall_clr;
    @(posedge clock) disable iff (!reset_n)
      (wen_prev_reg && !wen_reg) |=> (tag_reg == '0);
  endproperty
  a_wen_fall_clr: assert property (p_wen_fall_clr) else $error("buffer kept on fall");

  property p_page_keep;
    @(posedge clock) disable iff (!reset_n)
      (cpu_wr.data_we && !cpu_wr.addr_we)
        |=> eeprom_addr_reg[DEW_ADDR_W-1:DEW_BYTE_W]
            == $past(eeprom_addr_reg[DEW_ADDR_W-1:DEW_BYTE_W]);
  endproperty
  a_page_keep: assert property (p_page_keep) else $error("page bits changed");

  property p_saturate;
    @(posedge clock) disable iff (!reset_n)
      (eeprom_addr_reg[DEW_BYTE_W-1:0] == DEW_BYTE_LAST && !cpu_wr.addr_we)
        |=> eeprom_addr_reg[DEW_BYTE_W-1:0] == DEW_BYTE_LAST;
  endproperty
  a_saturate: assert property (p_saturate) else $error("offset wrapped");

  property p_byte_erase;
    @(posedge clock) disable iff (!reset_n)
      (activate && !mode_reg) |=> state_reg == DEW_ERASE ##1 nvm_req.erase;
  endproperty
  a_byte_erase: assert property (p_byte_erase) else $error("no erase before program");

  property p_vector;
    @(posedge clock) disable iff (!reset_n)
      int_vector_req |-> $past(global_int_enable && eeprom_int_enable && !stack_full);
  endproperty
  a_vector: assert property (p_vector) else $error("vector without enables");

  property p_sector;
    @(posedge clock) disable iff (!reset_n)
      !sel_ok |=> $stable(mode_reg);
  endproperty
  a_sector: assert property (p_sector) else $error("control changed off sector");

  property p_page_direct;
    @(posedge clock) disable iff (!reset_n)
      (activate && mode_reg) |=> state_reg == DEW_PROG;
  endproperty
  a_page_direct: assert property (p_page_direct) else $error("page write not started");

  property p_ack_clear;
    @(posedge clock) disable iff (!reset_n)
      (int_ack && !(done_pulse && wst_reg)) |=> !mf_int_flag;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("service left flag set");
endmodule

// >>> dew_timer_model.sv
// Model of the asynchronous write timer behind the array request
`timescale 1ns/10ps
module dew_timer_model
  import dew_pkg::*;
#(
  parameter int DONE_NS = 1713
) (
  // Array request
  input  wire dew_pkg::dew_nvm_req_t nvm_req,
  // Done level
  output logic                       timer_done
);
  // ==================================================
  // Timer
  initial timer_done = 1'b0;
  always begin
    wait (nvm_req.prog === 1'b1);
    // Not a whole number of clock periods
    #(DONE_NS);
    timer_done = 1'b1;
    wait (nvm_req.prog !== 1'b1);
    timer_done = 1'b0;
  end
endmodule

// >>> dew_ctrl_bench.sv
// Testbench for the data EEPROM write controller
`timescale 1ns/10ps
module dew_ctrl_bench;
  import dew_pkg::*;
  // ==================================================
  // Signals
  logic          clock             = 1'b0;
  logic          reset_n           = 1'b0;
  dew_cpu_wr_t   cpu_wr            = '0;
  logic          ptr_we            = 1'b0;
  logic [7:0]    ptr_wdata         = 8'h00;
  logic          global_int_enable = 1'b1;
  logic          eeprom_int_enable = 1'b1;
  logic          mf_int_enable     = 1'b1;
  logic          stack_full        = 1'b0;
  logic          int_ack           = 1'b0;
  logic          eeprom_flag_clr   = 1'b0;
  logic          timer_done;
  logic [7:0]    eeprom_ctrl_reg;
  logic [7:0]    mem_ptr1_high;
  logic [8:0]    eeprom_addr_reg;
  logic [7:0]    eeprom_data_reg;
  logic          eeprom_int_flag;
  logic          mf_int_flag;
  logic          int_vector_req;
  dew_nvm_req_t  nvm_req;
  logic [7:0]    nvm_wdata;
  logic [127:0]  page_buf_out;
  logic [15:0]   page_tag_out;
  int            error_cnt         = 0;
  int            tests_run         = 0;

  always #12.5 clock = ~clock;

  dew_ctrl #(.PAGE_BYTES(16)) dew_ctrl_inst (
    .clock(clock), .reset_n(reset_n), .cpu_wr(cpu_wr), .ptr_we(ptr_we),
    .ptr_wdata(ptr_wdata), .global_int_enable(global_int_enable),
    .eeprom_int_enable(eeprom_int_enable), .mf_int_enable(mf_int_enable),
    .stack_full(stack_full), .int_ack(int_ack), .eeprom_flag_clr(eeprom_flag_clr),
    .timer_done(timer_done), .eeprom_ctrl_reg(eeprom_ctrl_reg),
    .mem_ptr1_high(mem_ptr1_high), .eeprom_addr_reg(eeprom_addr_reg),
    .eeprom_data_reg(eeprom_data_reg), .eeprom_int_flag(eeprom_int_flag),
    .mf_int_flag(mf_int_flag), .int_vector_req(int_vector_req), .nvm_req(nvm_req),
    .nvm_wdata(nvm_wdata), .page_buf_out(page_buf_out), .page_tag_out(page_tag_out)
  );

  dew_timer_model dew_timer_model_inst (
    .nvm_req(nvm_req),
    .timer_done(timer_done)
  );

  // ==================================================
  // Tasks
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Kinds: 0 ctrl, 1 data, 2 addr, 3 pointer, 4 int ack, 5 flag clear
  task automatic wr(input int k, input logic [8:0] v);
    @(negedge clock);
    cpu_wr.ctrl_wdata = v[7:0];
    cpu_wr.data_wdata = v[7:0];
    cpu_wr.addr_wdata = v;
    ptr_wdata = v[7:0];
    {eeprom_flag_clr, int_ack, ptr_we, cpu_wr.addr_we, cpu_wr.data_we,
     cpu_wr.ctrl_we} = 6'h01 << k;
    @(negedge clock);
    {eeprom_flag_clr, int_ack, ptr_we, cpu_wr.addr_we, cpu_wr.data_we,
     cpu_wr.ctrl_we} = 6'h00;
  endtask

  // Two control writes in consecutive cycles, interrupts masked around them
  task automatic pair(input logic [7:0] a, input logic [7:0] b);
    @(negedge clock);
    global_int_enable = 1'b0;
    cpu_wr.ctrl_we = 1'b1;
    cpu_wr.ctrl_wdata = a;
    @(negedge clock);
    cpu_wr.ctrl_wdata = b;
    @(negedge clock);
    cpu_wr.ctrl_we = 1'b0;
    global_int_enable = 1'b1;
  endtask

  // Bounded wait: 0 for programming, 1 for write_start cleared
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (n < 4000 && ((sel == 0) ? (nvm_req.prog !== 1'b1)
                                   : (eeprom_ctrl_reg[2] !== 1'b0))) begin
      @(negedge clock);
      n++;
    end
    if (n == 4000) begin
      error_cnt++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask

  // ==================================================
  // Sequence
  initial begin
    idle(16);
    reset_n = 1'b1;
    chk(eeprom_ctrl_reg, 8'h00);
    chk(mem_ptr1_high, 8'h00);
    chk(page_buf_out, 128'h0);
    pair(8'h08, 8'h0C);
    idle(3);
    chk(eeprom_ctrl_reg, 8'h00);
    wr(3, 9'h001);
    idle(1);
    chk(mem_ptr1_high, 8'h01);
    wr(0, 9'h004);
    idle(3);
    chk(eeprom_ctrl_reg[2], 1'b0);
    wr(0, 9'h008);
    idle(2);
    chk(eeprom_ctrl_reg[3], 1'b0);
    wr(0, 9'h00C);
    idle(3);
    chk(eeprom_ctrl_reg[2], 1'b0);
    wr(0, 9'h000);
    // Byte write with the vector held off by a full stack
    wr(2, 9'h1A5);
    wr(1, 9'h03C);
    chk(eeprom_data_reg, 8'h3C);
    stack_full = 1'b1;
    pair(8'h08, 8'h0C);
    idle(2);
    chk(nvm_req, {3'b100, 9'h1A5});
    chk(eeprom_ctrl_reg[4:2], 3'b011);
    wait_for(0);
    chk(nvm_wdata, 8'h3C);
    wait_for(1);
    idle(1);
    chk(eeprom_ctrl_reg[3], 1'b0);
    chk({eeprom_int_flag, mf_int_flag, int_vector_req}, 3'b110);
    stack_full = 1'b0;
    idle(2);
    chk(int_vector_req, 1'b1);
    wr(4, 9'h000);
    idle(1);
    chk({eeprom_int_flag, mf_int_flag}, 2'b10);
    wr(5, 9'h000);
    idle(1);
    chk(eeprom_int_flag, 1'b0);
    // Page load across the last offset
    wr(0, 9'h010);
    wr(2, 9'h0AE);
    wr(1, 9'h011);
    wr(1, 9'h022);
    wr(1, 9'h033);
    idle(1);
    chk(eeprom_addr_reg, 9'h0AF);
    chk(page_buf_out[127:112], 16'h2211);
    chk(page_tag_out, 16'hC000);
    chk(page_buf_out[111:0], 112'h0);
    pair(8'h18, 8'h1C);
    idle(2);
    chk({nvm_req.erase, nvm_req.prog, nvm_req.page}, 3'b011);
    chk(nvm_req.addr[8:4], 5'h0A);
    wait_for(1);
    idle(2);
    chk(page_buf_out, 128'h0);
    // Enable rising keeps the buffer, falling clears it
    wr(2, 9'h0A0);
    wr(1, 9'h05A);
    wr(0, 9'h018);
    idle(2);
    chk(page_buf_out[7:0], 8'h5A);
    wr(0, 9'h010);
    idle(2);
    chk(page_buf_out, 128'h0);
    // Reset in mid-run with a byte held in the buffer
    wr(1, 9'h077);
    idle(1);
    chk(page_buf_out[15:8], 8'h77);
    reset_n = 1'b0;
    idle(2);
    reset_n = 1'b1;
    idle(2);
    chk(page_buf_out, 128'h0);
    chk(page_tag_out, 16'h0000);
    chk({eeprom_ctrl_reg, mem_ptr1_high}, 16'h0000);
    report_and_stop();
  end
endmodule
